// ---- hw/sppr_pkg.sv ----
// Package: offsets, field positions, reset values and page codes
package sppr_pkg;
    // Register offsets within the general and master address spaces
    localparam logic [11:0] SPPR_OFS_PTR_LOW = 12'h002;
    localparam logic [11:0] SPPR_OFS_PTR_MID = 12'h003;
    localparam logic [11:0] SPPR_OFS_PTR_HIGH = 12'h004;
    localparam logic [11:0] SPPR_OFS_WIRE_MODE = 12'h010;
    localparam logic [11:0] SPPR_OFS_CONV_PAGE = 12'h011;
    localparam logic [11:0] SPPR_OFS_PRIM_PAGE = 12'h012;
    localparam logic [11:0] SPPR_OFS_POWER_DOWN = 12'h020;
    // Field positions
    localparam int SPPR_BIT_THREE_WIRE = 0;
    localparam int SPPR_BIT_PRIM_PAGE = 2;
    localparam int SPPR_BIT_SYNC_OFF = 4;
    localparam int SPPR_BIT_CHB_OFF = 1;
    localparam int SPPR_BIT_ALL_OFF = 0;
    // Writable masks: other bits are write-only zeros and read back zero
    localparam logic [7:0] SPPR_MASK_WIRE_MODE = 8'h01;
    localparam logic [7:0] SPPR_MASK_PRIM_PAGE = 8'h04;
    localparam logic [7:0] SPPR_MASK_POWER_DOWN = 8'h17;
    localparam logic [7:0] SPPR_RESET_VALUE = 8'h00;
    localparam logic [7:0] SPPR_CONV_PAGE_ON = 8'hff;
    // Page pointer codes
    localparam logic [23:0] SPPR_PAGE_MAIN_A = 24'h680000;
    localparam logic [23:0] SPPR_PAGE_MAIN_B = 24'h680100;
    localparam logic [23:0] SPPR_PAGE_FUNC_A = 24'h610000;
    localparam logic [23:0] SPPR_PAGE_FUNC_B = 24'h610100;
    localparam logic [23:0] SPPR_PAGE_LINK = 24'h690000;

    typedef enum logic [2:0]
    {
        SPPR_SEL_NONE = 3'b000,
        SPPR_SEL_MAIN_A = 3'b001,
        SPPR_SEL_MAIN_B = 3'b010,
        SPPR_SEL_FUNC_A = 3'b011,
        SPPR_SEL_FUNC_B = 3'b100,
        SPPR_SEL_LINK = 3'b101
    } sppr_page_t;
endpackage : sppr_pkg

// ---- hw/sppr_regs.sv ----
// Register bank: page pointer, wire mode, page enables, power-down
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [R1] 24-bit page pointer; bits 15:8 mid register, 23:16 high register.
// [R2] Pointer bits 7:0 sit in the register below mid; RW, reset zero.
// [R3] Pointer decodes main and function pages for both channels, and one link page.
// [R4] Wire mode bit 0: 0 four-wire, 1 three-wire with shared data pin.
// [R5] Converter page byte all ones selects converter page; zero is normal.
// [R6] Page-enable bit 2 selects master page address space.
// [R7] Host never enables converter and master pages together.
// [R8] Power-down bit 4 stops sync-reference buffer; pulses then ignored.
// [R9] Power-down bit 1 switches channel B off.
// [R10] Power-down bit 0 puts whole device into power-down.
// [R11] Host writes zero to unused bits; all fields reset to zero.
module sppr_regs
    import sppr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register access from the serial port decoder
    input wire logic reg_wr,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Sync-reference pulse in and its gated copy
    input wire logic sync_reference_in,
    output logic sync_reference_pulse,
    // Configuration outputs
    output logic [23:0] page_pointer,
    output logic [2:0] page_target,
    output logic three_wire_mode,
    output logic converter_page_on,
    output logic primary_page_on,
    output logic sync_reference_buffer_off,
    output logic channel_b_off,
    output logic whole_device_off
);
    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic sppr_page_t sppr_decode(input logic [23:0] ptr);
        sppr_page_t sel;
        sel = SPPR_SEL_NONE;
        case (ptr)
            SPPR_PAGE_MAIN_A: sel = SPPR_SEL_MAIN_A; // R3
            SPPR_PAGE_MAIN_B: sel = SPPR_SEL_MAIN_B;
            SPPR_PAGE_FUNC_A: sel = SPPR_SEL_FUNC_A;
            SPPR_PAGE_FUNC_B: sel = SPPR_SEL_FUNC_B;
            SPPR_PAGE_LINK: sel = SPPR_SEL_LINK;
            default: sel = SPPR_SEL_NONE;
        endcase
        return sel;
    endfunction : sppr_decode

    // ------------------------------------------------------------
    // Page pointer and decoded target
    // ------------------------------------------------------------
    logic [7:0] ptr_low_q;
    logic [7:0] ptr_low_d;
    logic [7:0] ptr_mid_q;
    logic [7:0] ptr_mid_d;
    logic [7:0] ptr_high_q;
    logic [7:0] ptr_high_d;
    sppr_page_t target_q;
    sppr_page_t target_d;

    always_comb
    begin
        ptr_low_d = ptr_low_q;
        ptr_mid_d = ptr_mid_q;
        ptr_high_d = ptr_high_q;
        if (reg_wr)
        begin
            case (reg_addr)
                SPPR_OFS_PTR_LOW: ptr_low_d = reg_wdata; // R2
                SPPR_OFS_PTR_MID: ptr_mid_d = reg_wdata; // R1
                SPPR_OFS_PTR_HIGH: ptr_high_d = reg_wdata; // R1
                default: ;
            endcase
        end
        // Decode the next value so the target follows each byte write
        target_d = sppr_decode({ptr_high_d, ptr_mid_d, ptr_low_d}); // R3
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ptr_low_q <= SPPR_RESET_VALUE; // R2
            ptr_mid_q <= SPPR_RESET_VALUE;
            ptr_high_q <= SPPR_RESET_VALUE;
            target_q <= SPPR_SEL_NONE;
        end
        else
        begin
            ptr_low_q <= ptr_low_d;
            ptr_mid_q <= ptr_mid_d;
            ptr_high_q <= ptr_high_d;
            target_q <= target_d;
        end
    end

    // ------------------------------------------------------------
    // Port mode, page enables and power-down
    // ------------------------------------------------------------
    logic [7:0] wire_mode_q;
    logic [7:0] wire_mode_d;
    logic [7:0] conv_page_q;
    logic [7:0] conv_page_d;
    logic conv_on_q;
    logic conv_on_d;
    logic [7:0] prim_page_q;
    logic [7:0] prim_page_d;
    logic [7:0] power_down_q;
    logic [7:0] power_down_d;

    always_comb
    begin
        wire_mode_d = wire_mode_q;
        conv_page_d = conv_page_q;
        prim_page_d = prim_page_q;
        power_down_d = power_down_q;
        if (reg_wr)
        begin
            case (reg_addr)
                SPPR_OFS_WIRE_MODE:
                    wire_mode_d = reg_wdata & SPPR_MASK_WIRE_MODE; // R4
                SPPR_OFS_CONV_PAGE: conv_page_d = reg_wdata; // R5
                SPPR_OFS_PRIM_PAGE:
                    prim_page_d = reg_wdata & SPPR_MASK_PRIM_PAGE; // R6
                SPPR_OFS_POWER_DOWN:
                    // Master-page register: only reachable with page on
                    if (prim_page_q[SPPR_BIT_PRIM_PAGE]) // R6
                    begin
                        power_down_d = reg_wdata & SPPR_MASK_POWER_DOWN;
                    end
                default: ;
            endcase
        end
        // Only all ones selects the page; registered to keep a clean output
        conv_on_d = (conv_page_d == SPPR_CONV_PAGE_ON); // R5
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wire_mode_q <= SPPR_RESET_VALUE; // R11
            conv_page_q <= SPPR_RESET_VALUE;
            conv_on_q <= 1'b0;
            prim_page_q <= SPPR_RESET_VALUE;
            power_down_q <= SPPR_RESET_VALUE;
        end
        else
        begin
            wire_mode_q <= wire_mode_d;
            conv_page_q <= conv_page_d;
            conv_on_q <= conv_on_d;
            prim_page_q <= prim_page_d;
            power_down_q <= power_down_d;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb
    begin
        // Readback reflects stored state, including bit 2 of power-down; power-down reads zero while the master page is off
        case (reg_addr)
            SPPR_OFS_PTR_LOW: rdata_d = ptr_low_q;
            SPPR_OFS_PTR_MID: rdata_d = ptr_mid_q;
            SPPR_OFS_PTR_HIGH: rdata_d = ptr_high_q;
            SPPR_OFS_WIRE_MODE: rdata_d = wire_mode_q;
            SPPR_OFS_CONV_PAGE: rdata_d = conv_page_q;
            SPPR_OFS_PRIM_PAGE: rdata_d = prim_page_q;
            SPPR_OFS_POWER_DOWN:
                rdata_d = prim_page_q[SPPR_BIT_PRIM_PAGE] ?
                    power_down_q : SPPR_RESET_VALUE;
            default: rdata_d = SPPR_RESET_VALUE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_q <= SPPR_RESET_VALUE;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Sync-reference gate
    // ------------------------------------------------------------
    logic sync_q;
    logic sync_d;

    always_comb
    begin
        // Buffer off drops every incoming pulse
        sync_d = sync_reference_in & ~power_down_q[SPPR_BIT_SYNC_OFF]; // R8
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign sync_reference_pulse = sync_q;
    assign page_pointer = {ptr_high_q, ptr_mid_q, ptr_low_q}; // R1
    assign page_target = target_q;
    assign three_wire_mode = wire_mode_q[SPPR_BIT_THREE_WIRE]; // R4
    assign converter_page_on = conv_on_q; // R5
    assign primary_page_on = prim_page_q[SPPR_BIT_PRIM_PAGE]; // R6
    assign sync_reference_buffer_off = power_down_q[SPPR_BIT_SYNC_OFF]; // R8
    assign channel_b_off = power_down_q[SPPR_BIT_CHB_OFF]; // R9
    assign whole_device_off = power_down_q[SPPR_BIT_ALL_OFF]; // R10
endmodule : sppr_regs

`default_nettype wire

// ---- testbench/sppr_assertions.sv ----
// Checker for the page select and power-down bank
`timescale 1ns/1ps
`default_nettype none
module sppr_assertions
    import sppr_pkg::*;
(
    // Clock, reset and write port
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // Outputs
    input wire logic [23:0] page_pointer,
    input wire logic three_wire_mode,
    input wire logic converter_page_on,
    input wire logic primary_page_on,
    input wire logic sync_reference_pulse,
    input wire logic sync_reference_buffer_off,
    input wire logic channel_b_off,
    input wire logic whole_device_off
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Idle port maps to an address no register uses
    wire logic [11:0] wa = reg_wr ? reg_addr : 12'hfff;
    wire logic [2:0] pd = {sync_reference_buffer_off, channel_b_off,
        whole_device_off};
    a_ptr_high: assert property (wa == SPPR_OFS_PTR_HIGH
        |=> page_pointer[23:16] == $past(reg_wdata)) else $error("high");
    a_ptr_mid: assert property (wa == SPPR_OFS_PTR_MID
        |=> page_pointer[15:8] == $past(reg_wdata)) else $error("mid");
    a_ptr_low: assert property (wa == SPPR_OFS_PTR_LOW
        |=> page_pointer[7:0] == $past(reg_wdata)) else $error("low");
    a_wire_set: assert property (wa == SPPR_OFS_WIRE_MODE
        |=> three_wire_mode == $past(reg_wdata[0])) else $error("wire");
    a_conv_on: assert property (wa == SPPR_OFS_CONV_PAGE
        |=> converter_page_on == ($past(reg_wdata) == 8'hff)) else $error("cv");
    a_prim_on: assert property (wa == SPPR_OFS_PRIM_PAGE
        |=> primary_page_on == $past(reg_wdata[2])) else $error("prim");
    a_pd_write: assert property (wa == 12'h020 && primary_page_on
        |=> pd == {$past(reg_wdata[4]), $past(reg_wdata[1]),
        $past(reg_wdata[0])}) else $error("pd");
    a_pd_locked: assert property (wa == 12'h020 && !primary_page_on
        |=> $stable(pd)) else $error("locked");
    a_sync_block: assert property (
        sync_reference_buffer_off && $past(sync_reference_buffer_off)
        |-> !sync_reference_pulse) else $error("sync");
endmodule : sppr_assertions
`default_nettype wire

// ---- testbench/sppr_host.sv ----
// Host model: byte writes and reads
`timescale 1ns/1ps
`default_nettype none
module sppr_host
(
    // Port
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic [11:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial {reg_wr, reg_addr, reg_wdata} = '0;
    task automatic wr(logic [11:0] a, logic [7:0] d);
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // Stale data inverted so a late sample cannot pass
        reg_wdata <= ~d;
        #1;
    endtask : wr
    task automatic rd(logic [11:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        repeat (2) @(posedge sys_clk);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : sppr_host
`default_nettype wire

// ---- testbench/sppr_regs_tb.sv ----
// Testbench for the page select and power-down bank
`timescale 1ns/1ps
`default_nettype none
module sppr_regs_tb
    import sppr_pkg::*;
();
    logic sys_clk = '0, reset_n = '0, sync_reference_in = '0, reg_wr;
    logic three_wire_mode, converter_page_on, primary_page_on;
    logic sync_reference_pulse, sync_reference_buffer_off, channel_b_off;
    logic whole_device_off;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic [23:0] page_pointer;
    logic [2:0] page_target;
    int n_fail = 0, num_checks = 0, bl [3] = '{0, 1, 4};
    logic [23:0] pg_ptr [5] = '{SPPR_PAGE_MAIN_A, SPPR_PAGE_MAIN_B,
        SPPR_PAGE_FUNC_A, SPPR_PAGE_FUNC_B, SPPR_PAGE_LINK};
    sppr_page_t pg_sel [5] = '{SPPR_SEL_MAIN_A, SPPR_SEL_MAIN_B,
        SPPR_SEL_FUNC_A, SPPR_SEL_FUNC_B, SPPR_SEL_LINK};
    always #2 sys_clk = ~sys_clk;
    sppr_host host
    (
        .sys_clk(sys_clk),
        .reg_rdata(reg_rdata),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata)
    );
    sppr_regs uut
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .sync_reference_in(sync_reference_in),
        .sync_reference_pulse(sync_reference_pulse),
        .page_pointer(page_pointer),
        .page_target(page_target),
        .three_wire_mode(three_wire_mode),
        .converter_page_on(converter_page_on),
        .primary_page_on(primary_page_on),
        .sync_reference_buffer_off(sync_reference_buffer_off),
        .channel_b_off(channel_b_off),
        .whole_device_off(whole_device_off)
    );
    task automatic chk(string nm, logic [23:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    task automatic sync_try(logic exp);
        @(posedge sys_clk) sync_reference_in <= 1'b1;
        @(posedge sys_clk) sync_reference_in <= 1'b0;
        #1 chk("sync", sync_reference_pulse, exp);
    endtask : sync_try
    // -------------------------------------------------
    // Stimulus
    // -------------------------------------------------
    initial
    begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 40; a++)
        begin
            host.rd(12'(a), rv);
            chk("reset", rv, '0);
        end
        $display("reset test done");
        foreach (pg_ptr[k])
        begin
            host.wr(SPPR_OFS_PTR_LOW, pg_ptr[k][7:0]);
            host.wr(SPPR_OFS_PTR_MID, pg_ptr[k][15:8]);
            host.wr(SPPR_OFS_PTR_HIGH, pg_ptr[k][23:16]);
            chk("target", page_target, 24'(pg_sel[k]));
        end
        chk("pointer", page_pointer, SPPR_PAGE_LINK);
        host.wr(SPPR_OFS_PTR_LOW, 8'h5a);
        chk("no page", page_target, 24'(SPPR_SEL_NONE));
        host.rd(SPPR_OFS_PTR_LOW, rv);
        chk("low read", rv, 8'h5a);
        host.wr(SPPR_OFS_WIRE_MODE, 8'h01);
        host.rd(SPPR_OFS_WIRE_MODE, rv);
        chk("wire", {three_wire_mode, rv}, 24'h101);
        host.wr(SPPR_OFS_CONV_PAGE, SPPR_CONV_PAGE_ON);
        host.wr(12'h020, 8'h01);
        chk("locked", {converter_page_on, whole_device_off}, 2'b10);
        host.wr(SPPR_OFS_CONV_PAGE, 8'h00);
        host.wr(SPPR_OFS_PRIM_PAGE, 8'h04);
        chk("pages", {converter_page_on, primary_page_on}, 2'b01);
        $display("page test done");
        foreach (bl[k])
        begin
            host.wr(12'h020, 8'(1 << bl[k]));
            chk("pd", {sync_reference_buffer_off, channel_b_off,
                whole_device_off}, bl[k] == 4 ? 4 : 1 << bl[k]);
        end
        host.rd(12'h020, rv);
        chk("pd read", rv, 8'h10);
        sync_try(1'b0);
        host.wr(12'h020, 8'h00);
        sync_try(1'b1);
        $display("power test done");
        conclude();
    end
endmodule : sppr_regs_tb
bind sppr_regs sppr_assertions chk_i
(
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .page_pointer(page_pointer),
    .three_wire_mode(three_wire_mode),
    .converter_page_on(converter_page_on),
    .primary_page_on(primary_page_on),
    .sync_reference_pulse(sync_reference_pulse),
    .sync_reference_buffer_off(sync_reference_buffer_off),
    .channel_b_off(channel_b_off),
    .whole_device_off(whole_device_off)
);
`default_nettype wire
